// ---- counter_increment_event_latch.sv ----
// Counter increment event latch and mask with a plain register port
`timescale 1ns/1ps
module counter_increment_event_latch (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic token_arrival_count_inc_i,
  input wire logic frame_sent_count_inc_i,
  input wire logic frame_uncaptured_count_inc_i,
  input wire logic frame_captured_count_inc_i,
  input wire logic frame_loss_count_inc_i,
  input wire logic isolated_error_count_inc_i,
  input wire logic frame_arrival_count_inc_i,
  output logic [7:0] masked_event_o,
  output logic counter_event_o
);

  logic [7:0] event_set;
  logic [7:0] latch_clear;
  logic [7:0] latch_flags;
  logic [7:0] mask_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic latch_wr;
  logic mask_wr;

  assign latch_wr = wr_i && (addr_i == counter_increment_event_pkg::LATCH_OFFSET);
  assign mask_wr = wr_i && (addr_i == counter_increment_event_pkg::MASK_OFFSET);

  always_comb begin
    event_set = 8'h00;
    event_set[counter_increment_event_pkg::TOKEN_ARRIVAL_BIT] =
      token_arrival_count_inc_i;
    event_set[counter_increment_event_pkg::FRAME_SENT_BIT] =
      frame_sent_count_inc_i;
    event_set[counter_increment_event_pkg::FRAME_UNCAPTURED_BIT] =
      frame_uncaptured_count_inc_i;
    event_set[counter_increment_event_pkg::FRAME_CAPTURED_BIT] =
      frame_captured_count_inc_i;
    event_set[counter_increment_event_pkg::FRAME_FORMAT_LOSS_BIT] =
      frame_loss_count_inc_i;
    event_set[counter_increment_event_pkg::ISOLATED_ERROR_BIT] =
      isolated_error_count_inc_i;
    event_set[counter_increment_event_pkg::FRAME_ARRIVAL_BIT] =
      frame_arrival_count_inc_i;
  end

  // Write-one-to-clear keeps unserviced bits safe from a read-modify-write race
  assign latch_clear = latch_wr ? (wdata_i & counter_increment_event_pkg::IMPLEMENTED_BITS)
                                : 8'h00;

  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < 8; bit_idx++) begin : g_latch
      if (counter_increment_event_pkg::IMPLEMENTED_BITS[bit_idx]) begin : g_used
        event_latch_bit u_bit (
          .clk_i(clk_i),
          .arst_n_i(arst_n_i),
          .set_i(event_set[bit_idx]),
          .clear_i(latch_clear[bit_idx]),
          .flag_o(latch_flags[bit_idx])
        );
      end else begin : g_reserved
        assign latch_flags[bit_idx] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mask_q <= counter_increment_event_pkg::MASK_RESET;
    end else if (mask_wr) begin
      mask_q <= wdata_i & counter_increment_event_pkg::IMPLEMENTED_BITS;
    end
  end

  always_comb begin
    rdata_d = counter_increment_event_pkg::UNMAPPED_READ;
    if (rd_i) begin
      if (addr_i == counter_increment_event_pkg::LATCH_OFFSET) begin
        rdata_d = latch_flags;
      end else if (addr_i == counter_increment_event_pkg::MASK_OFFSET) begin
        rdata_d = mask_q;
      end
    end
  end

  // Read data stands only in the cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  assign rdata_o = rdata_q;
  assign masked_event_o = latch_flags & mask_q;
  assign counter_event_o = |(latch_flags & mask_q);

endmodule // counter_increment_event_latch

// ---- counter_increment_event_monitor.sv ----
// Port checker for the counter increment event latch
`timescale 1ns/1ps
module counter_increment_event_monitor (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic token_arrival_count_inc_i,
  input wire logic frame_sent_count_inc_i,
  input wire logic frame_uncaptured_count_inc_i,
  input wire logic frame_captured_count_inc_i,
  input wire logic frame_loss_count_inc_i,
  input wire logic isolated_error_count_inc_i,
  input wire logic frame_arrival_count_inc_i,
  input wire logic [7:0] masked_event_o,
  input wire logic counter_event_o
);
  wire logic [7:0] ev = {1'b0, token_arrival_count_inc_i, frame_sent_count_inc_i,
    frame_uncaptured_count_inc_i, frame_captured_count_inc_i, frame_loss_count_inc_i,
    isolated_error_count_inc_i, frame_arrival_count_inc_i};
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  AST_SET: assert property (rd_i && addr_i == 8'h18 && $past(arst_n_i)
    |=> (rdata_o & $past(ev, 2)) == $past(ev, 2)) else $error("event not latched");
  AST_RES: assert property (masked_event_o[7] == 1'b0) else $error("bit 7 set");
  AST_OR: assert property (counter_event_o == |masked_event_o) else $error("bad or");
  AST_MASK: assert property (wr_i && addr_i == 8'h19 && wdata_i == 8'h00
    |=> !counter_event_o) else $error("mask ignored");
  AST_RST: assert property ($rose(arst_n_i) |-> masked_event_o == 8'h00) else $error("mask");
  AST_HOLD: assert property (!wr_i
    |=> (masked_event_o & $past(masked_event_o)) == $past(masked_event_o)) else $error("lost");
  AST_CLR: assert property (wr_i && addr_i == 8'h18 && wdata_i == 8'hFF && ev == 8'h00
    |=> masked_event_o == 8'h00) else $error("no clear");
  AST_IDLE: assert property (!rd_i |=> rdata_o == 8'h00) else $error("rdata idle");
  AST_UNM: assert property (rd_i && addr_i[7:1] != 7'h0C |=> rdata_o == 8'h00)
    else $error("unmapped read");
endmodule // counter_increment_event_monitor

bind counter_increment_event_latch counter_increment_event_monitor
  counter_increment_event_monitor_inst (.*);

// ---- counter_increment_event_pkg.sv ----
// Offsets, field positions and reset values of the counter increment event latch
package counter_increment_event_pkg;

  localparam int unsigned ADDR_WIDTH = 8;
  localparam int unsigned DATA_WIDTH = 8;
  localparam int unsigned EVENT_COUNT = 7;

  localparam logic [ADDR_WIDTH-1:0] LATCH_OFFSET = 8'h18;
  localparam logic [ADDR_WIDTH-1:0] MASK_OFFSET = 8'h19;

  localparam int unsigned FRAME_ARRIVAL_BIT = 0;
  localparam int unsigned ISOLATED_ERROR_BIT = 1;
  localparam int unsigned FRAME_FORMAT_LOSS_BIT = 2;
  localparam int unsigned FRAME_CAPTURED_BIT = 3;
  localparam int unsigned FRAME_UNCAPTURED_BIT = 4;
  localparam int unsigned FRAME_SENT_BIT = 5;
  localparam int unsigned TOKEN_ARRIVAL_BIT = 6;
  localparam int unsigned RESERVED_BIT = 7;

  localparam logic [DATA_WIDTH-1:0] LATCH_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] MASK_RESET = 8'h00;
  localparam logic [DATA_WIDTH-1:0] IMPLEMENTED_BITS = 8'h7F;
  localparam logic [DATA_WIDTH-1:0] UNMAPPED_READ = 8'h00;

endpackage

// ---- event_latch_bit.sv ----
// One sticky latch bit: set by an event, cleared by software, set wins
`timescale 1ns/1ps
module event_latch_bit (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic set_i,
  input wire logic clear_i,
  output logic flag_o
);

  logic flag_q;
  logic flag_d;

  always_comb begin
    flag_d = flag_q;
    if (clear_i) begin
      flag_d = 1'b0;
    end
    // An increment in the clearing cycle must not be lost
    if (set_i) begin
      flag_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign flag_o = flag_q;

endmodule // event_latch_bit

// ---- testbench.sv ----
// Random and corner stimulus for the counter increment event latch
`timescale 1ns/1ps
module testbench;
  logic clk_i = 0, arst_n_i = 0, wr_i = 0, rd_i = 0;
  logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, lat, msk, rexp;
  logic [6:0] ev = 7'h00;
  logic [31:0] r;
  wire logic [7:0] rdata_o, masked_event_o;
  wire logic counter_event_o;
  int bad_count = 0, checks = 0;
  integer seed = 32'h0dddaf41;
  always #20 clk_i = ~clk_i;
  counter_increment_event_latch counter_increment_event_latch_inst (.*,
    .token_arrival_count_inc_i(ev[6]), .frame_sent_count_inc_i(ev[5]),
    .frame_uncaptured_count_inc_i(ev[4]), .frame_captured_count_inc_i(ev[3]),
    .frame_loss_count_inc_i(ev[2]), .isolated_error_count_inc_i(ev[1]),
    .frame_arrival_count_inc_i(ev[0]));
  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bus(logic w, logic rv, logic [7:0] a, logic [7:0] d);
    wr_i <= w;
    rd_i <= rv;
    addr_i <= a;
    wdata_i <= d;
  endtask
  // Set wins over a same-cycle clear
  always @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lat <= 8'h00;
      msk <= 8'h00;
      rexp <= 8'h00;
    end else begin
      lat <= (lat & ~((wr_i && addr_i == 8'h18) ? wdata_i : 8'h00)) | {1'b0, ev};
      if (wr_i && addr_i == 8'h19) msk <= wdata_i & 8'h7F;
      rexp <= !rd_i ? 8'h00 : addr_i == 8'h18 ? lat : addr_i == 8'h19 ? msk : 8'h00;
    end
  end
  always @(negedge clk_i) begin
    if (arst_n_i) begin
      check("rdata", rdata_o, rexp);
      check("masked", masked_event_o, lat & msk);
      check("irq", {7'h00, counter_event_o}, {7'h00, |(lat & msk)});
    end
  end
  initial begin
    repeat (5) @(posedge clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk_i);
      r = $random(seed);
      ev <= (i < 8 || i == 12) ? 7'h00 : (i == 10) ? 7'h7F : r[6:0] & r[13:7];
      if (i < 4) bus(1'b0, 1'b1, {7'h0C, i[0]}, 8'h00);
      else if (i > 9 && i < 13) bus(1'b1, 1'b0, i == 11 ? 8'h19 : 8'h18, i == 11 ? 8'h00 : 8'hFF);
      else bus(r[16], !r[16] && r[17], r[19:18] == 2'b00 ? r[31:24] : {7'h0C, r[18]}, r[27:20]);
    end
    close_out();
  end
  initial begin
    #100000;
    bad_count++;
    close_out();
  end
endmodule // testbench
